// *** hw/adc_clock_divider.sv ***
// Converter clock enable generator: one-cycle ticks at the slow or fast rate.
// Assumes restart_i and fast_i come from logic on the same clock.
`timescale 1ns/10ps
module adc_clock_divider
   import adc_ctrl_pkg::*;
#(
   parameter int DIV_SLOW_P = DIV_SLOW
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic fast_i,     // Select half CPU clock rate
   input  wire logic restart_i,  // Realign the divider
   output logic      tick_o      // Converter clock enable pulse
);

   localparam int CNT_W = $clog2(DIV_SLOW_P + 1);

   logic [CNT_W-1:0] count;      // Cycles since last tick
   logic [CNT_W-1:0] next_count;
   logic [CNT_W-1:0] limit;      // Terminal count for the chosen rate

   // Pick terminal count; fast gives a tick every second cycle
   always_comb begin
      limit = fast_i ? CNT_W'(DIV_FAST - 1) : CNT_W'(DIV_SLOW_P - 1);
      tick_o = (count >= limit);
   end

   // Count up, wrap on tick, clear on restart
   always_comb begin
      if (restart_i) begin
         next_count = '0;
      end else if (tick_o) begin
         next_count = '0;
      end else begin
         next_count = count + CNT_W'(1);
      end
   end

   // Register the counter
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // Fast rate spaces ticks exactly two cycles apart
   property p_fast_rate;
      @(posedge clk_i) disable iff (!rst_n_i)
      (tick_o && fast_i && !restart_i) ##1 !restart_i |-> !tick_o ##1 (!fast_i || tick_o);
   endproperty
   a_fast_rate: assert property (p_fast_rate)
      else $error("fast converter clock not at half CPU rate");

endmodule : adc_clock_divider

// *** hw/adc_conversion_control.sv ***
// Converter control: registers, converter clock, successive approximation sequencer.
// Assumes an analog mux and comparator outside; comp_i is asynchronous to clk_i.
`timescale 1ns/10ps

// Summary of operation
// - Speed bit runs converter at half CPU clock
// - Channel field selects the sampled input
// - Control write while enabled restarts conversion
// - New conversion begins at once, no wait
// - Done flag and result at conversion end
// - Continuous conversion unless single-shot variant
// - Result split high eight, low two
// - Only high register read clears done
// - Result halves overwritten each conversion, unlatched
module adc_conversion_control
   import adc_ctrl_pkg::*;
#(
   parameter bit SINGLE_SHOT = 1'b0,      // Stop after each conversion
   parameter int DIV_SLOW_P  = DIV_SLOW   // Default converter clock divide
) (
   input  wire logic            clk_i,
   input  wire logic            arst_n_i,   // Asynchronous reset, active low
   input  wire logic [1:0]      addr_i,     // Register offset
   input  wire logic [7:0]      wdata_i,    // Write data
   input  wire logic            we_i,       // Write strobe
   input  wire logic            re_i,       // Read strobe
   output logic      [7:0]      rdata_o,    // Read data, cycle after strobe
   input  wire logic            comp_i,     // Comparator: input above trial
   output logic      [CH_W-1:0] channel_o,  // Analog mux select
   output logic                 sample_o,   // Track phase of sample and hold
   output logic      [RES_W-1:0] trial_o    // Trial code to the DAC
);

   logic              rst_meta;      // Reset release, first stage
   logic              rst_n;         // Synchronised reset
   logic              comp_meta;     // Comparator, first stage
   logic              comp_sync;     // Comparator, usable copy
   logic              tick;          // Converter clock enable

   conv_state_t       state, next_state;
   logic [7:0]        ctrl, next_ctrl;             // Control register
   logic              done, next_done;             // Conversion done flag
   logic [RES_W-1:0]  result, next_result;         // Data registers
   logic [RES_W-1:0]  sar, next_sar;               // Approximation in progress
   logic [3:0]        bit_idx, next_bit_idx;       // Bit under trial
   logic [2:0]        cnt, next_cnt;               // Track phase ticks
   logic [7:0]        next_rdata;
   logic              wr_ctrl;                     // Control register write
   logic              rd_high;                     // High data register read
   logic              rd_low;                      // Low data register read
   logic              en;                          // Converter enabled
   logic              eoc;                         // End of conversion pulse
   logic [RES_W-1:0]  decided;                     // Sar after this decision

   // One-hot mask for a result bit
   function automatic logic [RES_W-1:0] bit_mask(input logic [3:0] idx);
      bit_mask = RES_W'(1) << idx;
   endfunction : bit_mask

   // Reset release synchroniser
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Comparator synchroniser
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         comp_meta <= 1'b0;
         comp_sync <= 1'b0;
      end else begin
         comp_meta <= comp_i;
         comp_sync <= comp_meta;
      end
   end

   // Register port decode
   always_comb begin
      wr_ctrl = we_i && (addr_i == OFS_CONTROL);
      rd_high = re_i && (addr_i == OFS_RESULT_HIGH);
      rd_low  = re_i && (addr_i == OFS_RESULT_LOW);
      en      = ctrl[CTRL_EN_BIT];
   end

   // Converter clock, realigned on each control write
   adc_clock_divider #(
      .DIV_SLOW_P (DIV_SLOW_P)
   ) u_div (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n),
      .fast_i    (ctrl[CTRL_FAST_BIT]),
      .restart_i (wr_ctrl),
      .tick_o    (tick)
   );

   // Decision on the bit under trial; keep it when the input lies above
   always_comb begin
      decided = comp_sync ? sar : (sar & ~bit_mask(bit_idx));
      eoc     = en && tick && (state == ST_DECIDE) && (bit_idx == 4'h0) && !wr_ctrl;
   end

   // Sequencer and register next values
   always_comb begin
      next_state   = state;
      next_ctrl    = ctrl;
      next_sar     = sar;
      next_bit_idx = bit_idx;
      next_cnt     = cnt;
      next_result  = result;
      if (wr_ctrl) begin
         // Any control write restarts; enabled means track at once
         next_ctrl    = wdata_i & CTRL_MASK;
         next_sar     = '0;
         next_bit_idx = 4'(RES_W - 1);
         next_cnt     = 3'h0;
         next_state   = wdata_i[CTRL_EN_BIT] ? ST_SAMPLE : ST_IDLE;
      end else if (!en) begin
         // Disabled: nothing runs
         next_state = ST_IDLE;
      end else if (tick) begin
         unique case (state)
            ST_IDLE: begin
               // Single-shot waits here for the next control write
               next_state = ST_IDLE;
            end
            ST_SAMPLE: begin
               if (cnt == 3'(SAMPLE_TICKS - 1)) begin
                  next_state   = ST_TRIAL;
                  next_sar     = bit_mask(4'(RES_W - 1));
                  next_bit_idx = 4'(RES_W - 1);
               end else begin
                  next_cnt = cnt + 3'h1;
               end
            end
            ST_TRIAL: begin
               // Let the comparator settle through its synchroniser
               next_state = ST_DECIDE;
            end
            ST_DECIDE: begin
               if (bit_idx == 4'h0) begin
                  // Result overwritten whole, no pairing with reads
                  next_result = decided;
                  next_sar    = '0;
                  next_cnt    = 3'h0;
                  next_state  = SINGLE_SHOT ? ST_IDLE : ST_SAMPLE;
               end else begin
                  next_sar     = decided | bit_mask(bit_idx - 4'h1);
                  next_bit_idx = bit_idx - 4'h1;
                  next_state   = ST_TRIAL;
               end
            end
         endcase
      end
   end

   // Done flag: set wins over the clearing read of the high register
   always_comb begin
      if (eoc) begin
         next_done = 1'b1;
      end else if (rd_high) begin
         next_done = 1'b0;
      end else begin
         next_done = done;
      end
   end

   // Read data mux; stands for one cycle only, zero otherwise
   always_comb begin
      next_rdata = 8'h00;
      if (re_i) begin
         unique case (addr_i)
            OFS_CONTROL:     next_rdata = ctrl;
            OFS_STATUS:      next_rdata = {6'h00, (state != ST_IDLE), done};
            OFS_RESULT_HIGH: next_rdata = result[RES_W-1:RES_LOW_W];
            OFS_RESULT_LOW:  next_rdata = {6'h00, result[RES_LOW_W-1:0]};
         endcase
      end
   end

   // State registers
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state   <= ST_IDLE;
         ctrl    <= CTRL_RESET;
         done    <= 1'b0;
         result  <= '0;
         sar     <= '0;
         bit_idx <= 4'h0;
         cnt     <= 3'h0;
         rdata_o <= 8'h00;
      end else begin
         state   <= next_state;
         ctrl    <= next_ctrl;
         done    <= next_done;
         result  <= next_result;
         sar     <= next_sar;
         bit_idx <= next_bit_idx;
         cnt     <= next_cnt;
         rdata_o <= next_rdata;
      end
   end

   // Outputs to the analog side
   always_comb begin
      channel_o = ctrl[CTRL_CH_LSB +: CH_W];
      sample_o  = (state == ST_SAMPLE);
      trial_o   = sar;
   end

   property p_channel;
      @(posedge clk_i) disable iff (!rst_n)
      wr_ctrl |=> channel_o == $past(wdata_i[CTRL_CH_LSB +: CH_W]);
   endproperty
   a_channel: assert property (p_channel)
      else $error("channel select not taken from control write");

   property p_restart;
      @(posedge clk_i) disable iff (!rst_n)
      (wr_ctrl && (state != ST_IDLE) && wdata_i[CTRL_EN_BIT]) |=> (trial_o == '0) && (bit_idx == 4'(RES_W - 1));
   endproperty
   a_restart: assert property (p_restart)
      else $error("control write did not abort conversion");

   property p_no_wait;
      @(posedge clk_i) disable iff (!rst_n)
      (wr_ctrl && wdata_i[CTRL_EN_BIT]) |=> sample_o && (cnt == 3'h0) && (trial_o == '0);
   endproperty
   a_no_wait: assert property (p_no_wait)
      else $error("new conversion did not start at once");

   property p_done_set;
      @(posedge clk_i) disable iff (!rst_n)
      eoc |=> done && (result == $past(decided));
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("done flag or result missing at conversion end");

   property p_continuous;
      @(posedge clk_i) disable iff (!rst_n)
      (eoc && !SINGLE_SHOT) |=> sample_o && (cnt == 3'h0);
   endproperty
   a_continuous: assert property (p_continuous)
      else $error("next conversion did not follow");

   property p_high_read;
      @(posedge clk_i) disable iff (!rst_n)
      rd_high |=> rdata_o == $past(result[RES_W-1:RES_LOW_W]);
   endproperty
   a_high_read: assert property (p_high_read)
      else $error("high data register content wrong");

   property p_high_clears;
      @(posedge clk_i) disable iff (!rst_n)
      (rd_high && !eoc) |=> !done;
   endproperty
   a_high_clears: assert property (p_high_clears)
      else $error("high register read did not clear done");

   property p_low_keeps;
      @(posedge clk_i) disable iff (!rst_n)
      (rd_low && done) |=> done;
   endproperty
   a_low_keeps: assert property (p_low_keeps)
      else $error("low register read changed done");

   property p_overwrite;
      @(posedge clk_i) disable iff (!rst_n)
      !eoc |=> $stable(result);
   endproperty
   a_overwrite: assert property (p_overwrite)
      else $error("result changed outside conversion end");

   property p_disabled;
      @(posedge clk_i) disable iff (!rst_n)
      (!en && !wr_ctrl && !done) |=> !done && !sample_o;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("activity while converter disabled");

endmodule : adc_conversion_control

// *** hw/adc_ctrl_pkg.sv ***
// Constants shared by the converter control block and its clock divider.
// Assumes an 8-bit register port and a 10-bit successive approximation core.
package adc_ctrl_pkg;

   // Register offsets on the plain register port
   localparam logic [1:0] OFS_CONTROL     = 2'h0;  // Enable, speed, channel
   localparam logic [1:0] OFS_STATUS      = 2'h1;  // Done flag, busy
   localparam logic [1:0] OFS_RESULT_HIGH = 2'h2;  // Result bits 9..2
   localparam logic [1:0] OFS_RESULT_LOW  = 2'h3;  // Result bits 1..0

   // Control register fields
   localparam int         CTRL_EN_BIT     = 0;     // Converter enable
   localparam int         CTRL_FAST_BIT   = 1;     // Converter clock at half CPU clock
   localparam int         CTRL_CH_LSB     = 2;     // Channel select, low bit
   localparam int         CH_W            = 3;     // Channel select width
   localparam logic [7:0] CTRL_MASK       = 8'h1f; // Implemented control bits
   localparam logic [7:0] CTRL_RESET      = 8'h00; // Disabled, slow, channel 0

   // Status register fields
   localparam int         STAT_DONE_BIT   = 0;     // Conversion done
   localparam int         STAT_BUSY_BIT   = 1;     // Conversion under way

   // Result layout
   localparam int         RES_W           = 10;    // Result width
   localparam int         RES_LOW_W       = 2;     // Bits held in the low register

   // Converter clock divides in CPU clock cycles, conversion timing in converter clock ticks
   localparam int         DIV_FAST        = 2;     // CPU clock divided by two
   localparam int         DIV_SLOW        = 4;     // Default slower divide
   localparam int         SAMPLE_TICKS    = 4;     // Track phase length

   // Conversion sequencer states, Gray coded in order from idle to decide
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_TRIAL  = 2'b11,
      ST_DECIDE = 2'b10
   } conv_state_t;

endpackage : adc_ctrl_pkg

// *** test/adc_analog_model.sv ***
// Behavioural analog side: input mux, sample and hold capacitor, comparator.
// Assumes the bench loads a level for each channel into lvl before use.
`timescale 1ns/10ps
module adc_analog_model
   import adc_ctrl_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic [CH_W-1:0]  channel_i,  // Mux select
   input  wire logic             sample_i,   // Track phase
   input  wire logic [RES_W-1:0] trial_i,    // Trial code from the DAC
   output logic                  comp_o      // Held level above trial
);
   logic [RES_W-1:0] lvl [8];      // Channel levels, set by the bench
   logic [RES_W-1:0] held = '0;    // Level on the hold capacitor
   // Track the selected channel while the sequencer samples
   always @(posedge clk_i) begin
      if (sample_i) begin
         held <= lvl[channel_i];
      end
   end
   // Level sits half a step above its code, so above and at-or-above agree
   assign comp_o = ({held, 1'b1} > {trial_i, 1'b0});
endmodule : adc_analog_model

// *** test/testbench.sv ***
// Self-checking bench for the converter control block.
// Assumes the analog model on the far side and the package constants.
`timescale 1ns/10ps
module testbench
   import adc_ctrl_pkg::*;
;
   logic             clk_i    = 1'b0;  // System clock
   logic             arst_n_i = 1'b0;  // Reset, active low
   logic [1:0]       addr_i   = 2'h0;  // Register offset
   logic [7:0]       wdata_i  = 8'h00; // Write data
   logic             we_i     = 1'b0;  // Write strobe
   logic             re_i     = 1'b0;  // Read strobe
   logic [7:0]       rdata_o;          // Read data
   logic             comp_i;           // Comparator
   logic [CH_W-1:0]  channel_o;        // Mux select
   logic             sample_o;         // Track phase
   logic [RES_W-1:0] trial_o;          // Trial code
   int               err_total   = 0;  // Mismatches
   int               check_count = 0;  // Comparisons
   int               cyc         = 0;  // Free cycle count
   logic             rd_valid    = 1'b0; // Read data due
   logic [8:0]       notes [$];        // Check flag and expected read data
   logic [8:0]       note;             // Oldest note
   logic [7:0]       v;                // Last read value
   logic [RES_W-1:0] lv;               // Level under test

   adc_conversion_control dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .comp_i(comp_i), .channel_o(channel_o),
      .sample_o(sample_o), .trial_o(trial_o));
   adc_analog_model analog (.clk_i(clk_i), .channel_i(channel_o), .sample_i(sample_o),
      .trial_i(trial_o), .comp_o(comp_i));

   // Clock, 10 ns period
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc      <= cyc + 1;
      rd_valid <= re_i;
   end

   // Compare and count
   task automatic chk(input string name, input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Read data watcher: takes the oldest note when data is due
   always @(negedge clk_i) begin
      if (rd_valid) begin
         note = notes.pop_front();
         if (note[8]) begin
            chk("rdata", {2'b00, rdata_o}, {2'b00, note[7:0]});
         end
      end
   end

   // One write cycle
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      we_i    <= 1'b1;
      @(posedge clk_i);
      we_i    <= 1'b0;
   endtask : wr

   // One read cycle; c set means compare with e
   task automatic rd(input logic [1:0] a, input logic c, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      re_i   <= 1'b1;
      notes.push_back({c, e});
      @(posedge clk_i);
      re_i <= 1'b0;
      #1 v = rdata_o;
   endtask : rd

   // Poll status until done, bounded
   task automatic poll();
      v = 8'h00;
      for (int i = 0; i < 300 && !v[STAT_DONE_BIT]; i++) begin
         rd(OFS_STATUS, 1'b0, 8'h00);
      end
      chk("done_seen", v[STAT_DONE_BIT], 1'b1);
   endtask : poll

   // Start a conversion and check time, result, flag clearing
   task automatic conv(input logic [2:0] ch, input logic fast);
      int t0;
      int d;
      d = fast ? DIV_FAST : DIV_SLOW;
      lv = $urandom_range(0, 1023);
      if (ch == 3'h0) lv = '0;
      if (ch == 3'h7) lv = '1;
      analog.lvl[ch] = lv;
      // Fast mode is taken as within the converter clock limit
      wr(OFS_CONTROL, {3'h0, ch, fast, 1'b1});
      t0 = cyc;
      #1 chk("sample_at_once", sample_o, 1'b1);
      rd(OFS_CONTROL, 1'b1, {3'h0, ch, fast, 1'b1});
      poll();
      chk("conv_time", (cyc - t0 >= 24 * d) && (cyc - t0 <= 26 * d + 8), 1'b1);
      rd(OFS_RESULT_LOW, 1'b1, {6'h00, lv[1:0]});
      rd(OFS_STATUS, 1'b1, 8'h03);
      rd(OFS_RESULT_HIGH, 1'b1, lv[9:2]);
      rd(OFS_STATUS, 1'b1, 8'h02);
   endtask : conv

   // Closing verdict
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   // Watchdog
   initial begin
      #400000;
      err_total++;
      results();
   end

   // Main sequence
   initial begin
      void'($urandom(59786));
      for (int i = 0; i < 8; i++) analog.lvl[i] = '0;
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      // Reset values, reserved bits, writes to read-only offsets
      rd(OFS_CONTROL, 1'b1, 8'h00);
      rd(OFS_STATUS, 1'b1, 8'h00);
      wr(OFS_CONTROL, 8'he0);
      wr(OFS_STATUS, 8'hff);
      rd(OFS_CONTROL, 1'b1, 8'h00);
      rd(OFS_STATUS, 1'b1, 8'h00);
      // Every channel at both rates
      for (int c = 0; c < 8; c++) begin
         conv(c[2:0], c[0]);
         conv(c[2:0], ~c[0]);
      end
      // Continuous run overwrites the result with no new write
      lv = $urandom_range(0, 1023);
      analog.lvl[7] = lv;
      // The conversion in flight may hold the old level; clear done and take the next one
      poll();
      rd(OFS_RESULT_HIGH, 1'b0, 8'h00);
      poll();
      rd(OFS_RESULT_HIGH, 1'b1, lv[9:2]);
      // Abort mid-conversion by a channel change
      wr(OFS_CONTROL, 8'h0b);
      repeat (20) @(posedge clk_i);
      conv(3'h5, 1'b0);
      // Disable: no conversion and no done flag
      wr(OFS_CONTROL, 8'h00);
      repeat (300) @(posedge clk_i);
      rd(OFS_STATUS, 1'b1, 8'h00);
      chk("sample_idle", sample_o, 1'b0);
      results();
   end
endmodule : testbench
